// >>> include/clf_pkg.sv
/*
  Holds the constants, types and register map of the charge level alarm block.
  Assumes a single 50 MHz clock domain and a synchronous active-high reset.
*/
//
// Overview of operation
// R1 - Integrate sensed charge into remaining capacity
// R2 - Impedance from loaded voltage versus derived OPEN_CIRCUIT_VOLTAGE
// R3 - Full charge capacity until termination voltage
// R4 - Report uncompensated nominal and full available capacity
// R5 - Set low capacity flag below threshold
// R6 - Clear low capacity flag above threshold
// R7 - Battery low pin follows low capacity flag
// R8 - Pin reflects flag only when enabled
// R9 - Set shutdown flag below set voltage, signal
// R10 - Clear shutdown flag above clear voltage, signal
// R11 - Force state of charge zero at final
// R12 - Both flags readable in status flags word
// R13 - One interrupt pulse per shutdown flag change
package clf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Configuration entries at their printed offsets
  localparam logic [7:0] OFF_QMAX_FILTER   = 8'h31;
  localparam logic [7:0] OFF_TERM_VOLT     = 8'h32;
  localparam logic [7:0] OFF_USER_CUR      = 8'h37;
  localparam logic [7:0] OFF_USER_PWR      = 8'h39;
  localparam logic [7:0] OFF_RSV_CHG       = 8'h3b;
  localparam logic [7:0] OFF_RSV_NRG       = 8'h3d;
  localparam logic [7:0] OFF_MIN_DV        = 8'h42;
  localparam logic [7:0] OFF_DSG_THR       = 8'h00;
  localparam logic [7:0] OFF_CHG_THR       = 8'h02;
  localparam logic [7:0] OFF_QUIT_CUR      = 8'h04;
  localparam logic [7:0] OFF_DSG_RELAX     = 8'h06;
  localparam logic [7:0] OFF_CHG_RELAX     = 8'h08;
  localparam logic [7:0] OFF_EXIT_RELAX    = 8'h09;
  // Block control and status words
  localparam logic [7:0] OFF_FLAGS         = 8'h80;
  localparam logic [7:0] OFF_OPCFG_B       = 8'h81;
  localparam logic [7:0] OFF_LOWCAP_THR    = 8'h82;
  localparam logic [7:0] OFF_SD_SET_V      = 8'h83;
  localparam logic [7:0] OFF_SD_CLR_V      = 8'h84;
  localparam logic [7:0] OFF_REM_CAP       = 8'h85;
  localparam logic [7:0] OFF_FULL_CAP      = 8'h86;
  localparam logic [7:0] OFF_NOM_CAP       = 8'h87;
  localparam logic [7:0] OFF_FAV_CAP       = 8'h88;
  localparam logic [7:0] OFF_SOC           = 8'h89;
  localparam logic [7:0] OFF_IMPEDANCE     = 8'h8a;
  localparam logic [7:0] OFF_INT_STATUS    = 8'h8b;
  localparam logic [7:0] OFF_INT_MASK      = 8'h8c;
  localparam logic [7:0] OFF_DESIGN_CAP    = 8'h8d;
  localparam logic [7:0] OFF_FINAL_V       = 8'h8e;

  // Reset values
  localparam logic [15:0] RST_QMAX_FILTER  = 16'h0060;
  localparam logic [15:0] RST_TERM_VOLT    = 16'h0d5c;
  localparam logic [15:0] RST_USER_CUR     = 16'h0000;
  localparam logic [15:0] RST_USER_PWR     = 16'h0000;
  localparam logic [15:0] RST_RSV_CHG      = 16'h0000;
  localparam logic [15:0] RST_RSV_NRG      = 16'h0000;
  localparam logic [15:0] RST_MIN_DV       = 16'h000f;
  localparam logic [15:0] RST_DSG_THR      = 16'h003c;
  localparam logic [15:0] RST_CHG_THR      = 16'h004b;
  localparam logic [15:0] RST_QUIT_CUR     = 16'h0028;
  localparam logic [15:0] RST_DSG_RELAX    = 16'h003c;
  localparam logic [15:0] RST_CHG_RELAX    = 16'h003c;
  localparam logic [15:0] RST_EXIT_RELAX   = 16'h0001;
  localparam logic [15:0] RST_OPCFG_B      = 16'h0001;
  localparam logic [15:0] RST_LOWCAP_THR   = 16'h0096;
  localparam logic [15:0] RST_SD_SET_V     = 16'h0c1c;
  localparam logic [15:0] RST_SD_CLR_V     = 16'h0c80;
  localparam logic [15:0] RST_DESIGN_CAP   = 16'h03e8;
  localparam logic [15:0] RST_FINAL_V      = 16'h0bb8;
  localparam logic [15:0] RST_INT_MASK     = 16'h0003;

  // Field positions
  localparam int unsigned FLG_LOWCAP_BIT   = 2;   // Status flags word
  localparam int unsigned FLG_SHUTDOWN_BIT = 1;
  localparam int unsigned OPB_PIN_EN_BIT   = 0;   // Operation config B
  localparam int unsigned INT_SD_BIT       = 0;   // Shutdown change event
  localparam int unsigned INT_LC_BIT       = 1;   // Low capacity change event
  localparam int unsigned INT_W            = 2;

  // Fraction scale for the state of charge report
  localparam logic [15:0] SOC_FULL         = 16'h0064;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic              wr;     // Write strobe
    logic              rd;     // Read strobe
    logic [ADDR_W-1:0] addr;   // Word address
    logic [DATA_W-1:0] wdata;  // Write data
  } clf_bus_s;

  typedef struct packed {
    logic        valid;        // New sample this cycle
    logic [15:0] voltage_mv;   // Loaded cell voltage
    logic [15:0] charge_mah;   // Charge quantum passed, magnitude
    logic        charging;     // Direction of the quantum
  } clf_meas_s;

endpackage : clf_pkg

// >>> design/clf_hyst.sv
/*
  Two-threshold hysteresis comparator that holds one flag.
  Assumes sample values and thresholds are stable on the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_hyst
  import clf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sample_en,
  input  wire logic [15:0] value,
  input  wire logic [15:0] set_below,
  input  wire logic [15:0] clear_above,
  output logic             flag,
  output logic             changed
);

  typedef struct packed {
    logic flag;
    logic changed;
  } clf_hyst_s;

  clf_hyst_s st_q;   // Registered state
  clf_hyst_s st_d;   // Next state

  // Set below one level, clear only above the other, so noise cannot chatter
  always_comb
  begin
    st_d         = st_q;
    st_d.changed = 1'b0;
    if (sample_en)
    begin
      if (!st_q.flag && (value < set_below))
      begin
        st_d.flag    = 1'b1;
        st_d.changed = 1'b1;
      end
      else if (st_q.flag && (value > clear_above))
      begin
        st_d.flag    = 1'b0;
        st_d.changed = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flag    = st_q.flag;
  assign changed = st_q.changed;

endmodule : clf_hyst
`default_nettype wire

// >>> design/clf_top.sv
/*
  Charge level alarm block: charge integration, capacity reports, low
  capacity and shutdown flags, battery low pin and interrupt output.
  Assumes measurements arrive from logic on the same clock, one sample
  per valid, and a register master that never waits.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_top
  import clf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire clf_pkg::clf_bus_s bus,
  output logic [clf_pkg::DATA_W-1:0] rdata,
  input  wire clf_pkg::clf_meas_s meas,
  output logic                   battery_low_pin,
  output logic                   charge_level_int,
  output logic                   irq
);
  import clf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] qmax_filter;
    logic [15:0] term_volt;
    logic [15:0] user_cur;
    logic [15:0] user_pwr;
    logic [15:0] rsv_chg;
    logic [15:0] rsv_nrg;
    logic [15:0] min_dv;
    logic [15:0] dsg_thr;
    logic [15:0] chg_thr;
    logic [15:0] quit_cur;
    logic [15:0] dsg_relax;
    logic [15:0] chg_relax;
    logic [15:0] exit_relax;
    logic [15:0] opcfg_b;
    logic [15:0] lowcap_thr;
    logic [15:0] sd_set_v;
    logic [15:0] sd_clr_v;
    logic [15:0] design_cap;
    logic [15:0] final_v;
    logic [15:0] rem_cap;
    logic [15:0] full_cap;
    logic [15:0] nom_cap;
    logic [15:0] fav_cap;
    logic [15:0] soc;
    logic [15:0] impedance;
    logic [15:0] last_v;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic        low_cap_flag;
    logic        pin;
    logic        pulse;
    logic        irq;
    logic [15:0] rdata;
  } clf_top_s;

  clf_top_s st_q;                  // Registered state
  clf_top_s st_d;                  // Next state

  logic       sd_flag;             // System shutdown flag from comparator
  logic       sd_changed;          // One-cycle change marker
  logic [15:0] ocv_est;            // Open circuit voltage for present charge
  logic [15:0] drop_mv;            // Loaded drop below the open circuit level
  logic [31:0] soc_prod;           // Scaled charge before division
  logic [15:0] flags_word;         // Status flags word image

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown voltage comparator, hysteresis between the set and clear levels
  clf_hyst u_sd_hyst (
    .clk         (clk),
    .rst         (rst),
    .sample_en   (meas.valid),
    .value       (meas.voltage_mv),
    .set_below   (st_q.sd_set_v),
    .clear_above (st_q.sd_clr_v),
    .flag        (sd_flag),            // [R9] [R10]
    .changed     (sd_changed)
  );

  // Open circuit voltage as a linear function of state of charge: a simple
  // stand-in for the cell curve, kept cheap since only the drop matters here
  always_comb
  begin
    ocv_est = 16'(st_q.final_v + 16'(st_q.soc * 16'h000c));   // [R2]
    if (ocv_est > meas.voltage_mv)
      drop_mv = 16'(ocv_est - meas.voltage_mv);
    else
      drop_mv = 16'h0000;
  end

  // Status flags word, both alarm flags in their bit positions
  always_comb
  begin
    flags_word = '0;
    flags_word[FLG_LOWCAP_BIT]   = st_q.low_cap_flag;    // [R12]
    flags_word[FLG_SHUTDOWN_BIT] = sd_flag;              // [R12]
  end

  assign soc_prod = 32'(st_q.rem_cap) * 32'(SOC_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_d       = st_q;
    st_d.pulse = 1'b0;
    st_d.rdata = '0;

    // Register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        OFF_QMAX_FILTER: st_d.qmax_filter = {8'h00, bus.wdata[7:0]};
        OFF_TERM_VOLT:   st_d.term_volt   = bus.wdata;
        OFF_USER_CUR:    st_d.user_cur    = bus.wdata;
        OFF_USER_PWR:    st_d.user_pwr    = bus.wdata;
        OFF_RSV_CHG:     st_d.rsv_chg     = bus.wdata;
        OFF_RSV_NRG:     st_d.rsv_nrg     = bus.wdata;
        OFF_MIN_DV:      st_d.min_dv      = bus.wdata;
        OFF_DSG_THR:     st_d.dsg_thr     = bus.wdata;
        OFF_CHG_THR:     st_d.chg_thr     = bus.wdata;
        OFF_QUIT_CUR:    st_d.quit_cur    = bus.wdata;
        OFF_DSG_RELAX:   st_d.dsg_relax   = bus.wdata;
        OFF_CHG_RELAX:   st_d.chg_relax   = {8'h00, bus.wdata[7:0]};
        OFF_EXIT_RELAX:  st_d.exit_relax  = {8'h00, bus.wdata[7:0]};
        OFF_OPCFG_B:     st_d.opcfg_b     = bus.wdata;
        OFF_LOWCAP_THR:  st_d.lowcap_thr  = bus.wdata;
        OFF_SD_SET_V:    st_d.sd_set_v    = bus.wdata;
        OFF_SD_CLR_V:    st_d.sd_clr_v    = bus.wdata;
        OFF_DESIGN_CAP:  st_d.design_cap  = bus.wdata;
        OFF_FINAL_V:     st_d.final_v     = bus.wdata;
        OFF_INT_MASK:    st_d.int_mask    = bus.wdata[INT_W-1:0];
        OFF_INT_STATUS:  st_d.int_status  = st_q.int_status & ~bus.wdata[INT_W-1:0];
        default:         st_d.qmax_filter = st_q.qmax_filter;   // Unmapped: ignored
      endcase
    end

    // Register reads, data stand one cycle later; unmapped reads zero
    if (bus.rd)
    begin
      unique case (bus.addr)
        OFF_QMAX_FILTER: st_d.rdata = st_q.qmax_filter;
        OFF_TERM_VOLT:   st_d.rdata = st_q.term_volt;
        OFF_USER_CUR:    st_d.rdata = st_q.user_cur;
        OFF_USER_PWR:    st_d.rdata = st_q.user_pwr;
        OFF_RSV_CHG:     st_d.rdata = st_q.rsv_chg;
        OFF_RSV_NRG:     st_d.rdata = st_q.rsv_nrg;
        OFF_MIN_DV:      st_d.rdata = st_q.min_dv;
        OFF_DSG_THR:     st_d.rdata = st_q.dsg_thr;
        OFF_CHG_THR:     st_d.rdata = st_q.chg_thr;
        OFF_QUIT_CUR:    st_d.rdata = st_q.quit_cur;
        OFF_DSG_RELAX:   st_d.rdata = st_q.dsg_relax;
        OFF_CHG_RELAX:   st_d.rdata = st_q.chg_relax;
        OFF_EXIT_RELAX:  st_d.rdata = st_q.exit_relax;
        OFF_OPCFG_B:     st_d.rdata = st_q.opcfg_b;
        OFF_LOWCAP_THR:  st_d.rdata = st_q.lowcap_thr;
        OFF_SD_SET_V:    st_d.rdata = st_q.sd_set_v;
        OFF_SD_CLR_V:    st_d.rdata = st_q.sd_clr_v;
        OFF_DESIGN_CAP:  st_d.rdata = st_q.design_cap;
        OFF_FINAL_V:     st_d.rdata = st_q.final_v;
        OFF_FLAGS:       st_d.rdata = flags_word;                // [R12]
        OFF_REM_CAP:     st_d.rdata = st_q.rem_cap;
        OFF_FULL_CAP:    st_d.rdata = st_q.full_cap;             // [R3]
        OFF_NOM_CAP:     st_d.rdata = st_q.nom_cap;              // [R4]
        OFF_FAV_CAP:     st_d.rdata = st_q.fav_cap;              // [R4]
        OFF_SOC:         st_d.rdata = st_q.soc;
        OFF_IMPEDANCE:   st_d.rdata = st_q.impedance;
        OFF_INT_STATUS:  st_d.rdata = {14'h0000, st_q.int_status};
        OFF_INT_MASK:    st_d.rdata = {14'h0000, st_q.int_mask};
        default:         st_d.rdata = 16'h0000;
      endcase
    end

    // Charge integration on each sample, saturating at both ends
    if (meas.valid)
    begin
      st_d.last_v = meas.voltage_mv;
      if (meas.charging)
      begin
        if (17'(st_q.rem_cap) + 17'(meas.charge_mah) > 17'(st_q.design_cap))
          st_d.rem_cap = st_q.design_cap;                        // [R1]
        else
          st_d.rem_cap = 16'(st_q.rem_cap + meas.charge_mah);    // [R1]
      end
      else if (st_q.rem_cap > meas.charge_mah)
        st_d.rem_cap = 16'(st_q.rem_cap - meas.charge_mah);      // [R1]
      else
        st_d.rem_cap = 16'h0000;                                 // [R1]
      // Impedance figure as the loaded drop below the open circuit level
      st_d.impedance = drop_mv;                                  // [R2]
      // At the final voltage the reported charge goes to empty
      if (meas.voltage_mv <= st_q.final_v)
        st_d.rem_cap = 16'h0000;                                 // [R11]
    end

    // Capacity reports: compensated figures lose the reserve held back
    // for the load, uncompensated ones do not
    st_d.fav_cap  = st_q.design_cap;                             // [R4]
    st_d.nom_cap  = st_q.rem_cap;                                // [R4]
    if (st_q.design_cap > st_q.rsv_chg)
      st_d.full_cap = 16'(st_q.design_cap - st_q.rsv_chg);       // [R3]
    else
      st_d.full_cap = 16'h0000;
    if (st_q.last_v <= st_q.term_volt && st_q.full_cap > st_q.rem_cap)
      st_d.full_cap = 16'(st_q.full_cap - st_q.rem_cap);         // [R3]

    // State of charge as a percentage of the design capacity
    if (st_q.design_cap == 16'h0000 || st_q.rem_cap == 16'h0000)
      st_d.soc = 16'h0000;                                       // [R11]
    else
      st_d.soc = 16'(soc_prod / 32'(st_q.design_cap));

    // Low capacity flag: set below the threshold, clear above it
    if (!st_q.low_cap_flag && st_q.rem_cap < st_q.lowcap_thr)
      st_d.low_cap_flag = 1'b1;                                  // [R5]
    else if (st_q.low_cap_flag && st_q.rem_cap > st_q.lowcap_thr)
      st_d.low_cap_flag = 1'b0;                                  // [R6]

    // Pin mirrors the flag while its enable is set
    st_d.pin = st_q.low_cap_flag & st_q.opcfg_b[OPB_PIN_EN_BIT]; // [R7] [R8]

    // One pulse per shutdown flag change
    st_d.pulse = sd_changed;                                     // [R13]

    // Sticky events: a set in the same cycle as a clear wins
    if (sd_changed)
      st_d.int_status[INT_SD_BIT] = 1'b1;
    if (st_d.low_cap_flag != st_q.low_cap_flag)
      st_d.int_status[INT_LC_BIT] = 1'b1;
    st_d.irq = |(st_d.int_status & st_d.int_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q             <= '0;
      st_q.qmax_filter <= RST_QMAX_FILTER;
      st_q.term_volt   <= RST_TERM_VOLT;
      st_q.user_cur    <= RST_USER_CUR;
      st_q.user_pwr    <= RST_USER_PWR;
      st_q.rsv_chg     <= RST_RSV_CHG;
      st_q.rsv_nrg     <= RST_RSV_NRG;
      st_q.min_dv      <= RST_MIN_DV;
      st_q.dsg_thr     <= RST_DSG_THR;
      st_q.chg_thr     <= RST_CHG_THR;
      st_q.quit_cur    <= RST_QUIT_CUR;
      st_q.dsg_relax   <= RST_DSG_RELAX;
      st_q.chg_relax   <= RST_CHG_RELAX;
      st_q.exit_relax  <= RST_EXIT_RELAX;
      st_q.opcfg_b     <= RST_OPCFG_B;
      st_q.lowcap_thr  <= RST_LOWCAP_THR;
      st_q.sd_set_v    <= RST_SD_SET_V;
      st_q.sd_clr_v    <= RST_SD_CLR_V;
      st_q.design_cap  <= RST_DESIGN_CAP;
      st_q.final_v     <= RST_FINAL_V;
      st_q.int_mask    <= RST_INT_MASK[INT_W-1:0];
    end
    else
      st_q <= st_d;
  end

  assign rdata            = st_q.rdata;
  assign battery_low_pin  = st_q.pin;
  assign charge_level_int = st_q.pulse;
  assign irq              = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lowcap_set;
    @(posedge clk) disable iff (rst)
      (!st_q.low_cap_flag && st_q.rem_cap < st_q.lowcap_thr) |=> st_q.low_cap_flag;
  endproperty
  a_lowcap_set: assert property (p_lowcap_set)   // [R5]
    else $error("low capacity flag not set");

  property p_lowcap_clr;
    @(posedge clk) disable iff (rst)
      (st_q.low_cap_flag && st_q.rem_cap > st_q.lowcap_thr) |=> !st_q.low_cap_flag;
  endproperty
  a_lowcap_clr: assert property (p_lowcap_clr)   // [R6]
    else $error("low capacity flag not cleared");

  property p_pin_follow;
    @(posedge clk) disable iff (rst)
      st_q.opcfg_b[OPB_PIN_EN_BIT] |=> (battery_low_pin == $past(st_q.low_cap_flag));
  endproperty
  a_pin_follow: assert property (p_pin_follow)   // [R7]
    else $error("battery low pin does not follow flag");

  property p_pin_gate;
    @(posedge clk) disable iff (rst)
      !st_q.opcfg_b[OPB_PIN_EN_BIT] |=> !battery_low_pin;
  endproperty
  a_pin_gate: assert property (p_pin_gate)   // [R8]
    else $error("battery low pin driven while disabled");

  property p_sd_set;
    @(posedge clk) disable iff (rst)
      (meas.valid && !sd_flag && meas.voltage_mv < st_q.sd_set_v)
        |=> sd_flag ##1 charge_level_int;
  endproperty
  a_sd_set: assert property (p_sd_set)   // [R9]
    else $error("shutdown set not signalled");

  property p_sd_clr;
    @(posedge clk) disable iff (rst)
      (meas.valid && sd_flag && meas.voltage_mv > st_q.sd_clr_v)
        |=> !sd_flag ##1 charge_level_int;
  endproperty
  a_sd_clr: assert property (p_sd_clr)   // [R10]
    else $error("shutdown clear not signalled");

  property p_one_pulse;
    @(posedge clk) disable iff (rst)
      charge_level_int |=> !charge_level_int;
  endproperty
  a_one_pulse: assert property (p_one_pulse)   // [R13]
    else $error("interrupt pulse longer than one cycle");

  property p_pulse_cause;
    @(posedge clk) disable iff (rst)
      $rose(charge_level_int) |-> $past(sd_flag) != $past(sd_flag, 2);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)   // [R13]
    else $error("interrupt pulse without flag change");

  property p_final_zero;
    @(posedge clk) disable iff (rst)
      (meas.valid && meas.voltage_mv <= st_q.final_v) |=> ##1 (st_q.soc == 16'h0000);
  endproperty
  a_final_zero: assert property (p_final_zero)   // [R11]
    else $error("state of charge not zero at final voltage");

  property p_integrate_dsg;
    @(posedge clk) disable iff (rst)
      (meas.valid && !meas.charging && meas.voltage_mv > st_q.final_v
        && st_q.rem_cap > meas.charge_mah)
        |=> st_q.rem_cap == $past(st_q.rem_cap) - $past(meas.charge_mah);
  endproperty
  a_integrate_dsg: assert property (p_integrate_dsg)   // [R1]
    else $error("discharge not integrated");

  property p_flags_read;
    @(posedge clk) disable iff (rst)
      (bus.rd && bus.addr == OFF_FLAGS)
        |=> rdata[FLG_SHUTDOWN_BIT] == $past(sd_flag);
  endproperty
  a_flags_read: assert property (p_flags_read)   // [R12]
    else $error("flags word does not show shutdown flag");

endmodule : clf_top
`default_nettype wire

// >>> bench/clf_host.sv
/*
  Host model: drives the register port and the measurement feed.
  Assumes one clock shared with the block and a slave that never waits.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_host
  import clf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdata,
  output var clf_pkg::clf_bus_s  bus,
  output var clf_pkg::clf_meas_s meas
);
  // Idle bus and feed from time zero
  initial
  begin
    bus  = '0;
    meas = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // One measurement sample: voltage, charge quantum and direction
  task automatic smp(input logic [15:0] v, input logic [15:0] q, input logic c);
    @(posedge clk);
    meas <= '{1'b1, v, q, c};
    @(posedge clk);
    meas.valid <= 1'b0;
  endtask : smp
endmodule : clf_host
`default_nettype wire

// >>> bench/testbench.sv
/*
  Self-checking bench for the charge level alarm block.
  Assumes the host model in clf_host and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench import clf_pkg::*;;
  logic              clk = 1'b0;          // 50 MHz clock
  logic              rst = 1'b1;          // Synchronous reset
  logic [DATA_W-1:0] rdata;               // Read data
  clf_bus_s          bus;                 // Register port
  clf_meas_s         meas;                // Measurement feed
  logic              pin;                 // Battery low pin
  logic              cl_int;              // Shutdown change pulse
  logic              irq;                 // Level interrupt
  logic [15:0]       d;                   // Read result
  int                miscompares = 0;     // Mismatch count
  int                cmp_count = 0;       // Comparison count
  int                cyc = 0;             // Cycles run
  logic [7:0]        ra [6] = '{8'h31, 8'h32, 8'h42, 8'h00, 8'h09, 8'h50};
  logic [15:0]       rv [6] = '{16'h0060, 16'h0d5c, 16'h000f, 16'h003c, 16'h0001, 16'h0000};
  always #10 clk = ~clk;
  clf_host u_host (.clk(clk), .rdata(rdata), .bus(bus), .meas(meas));
  clf_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .meas(meas),
    .battery_low_pin(pin), .charge_level_int(cl_int), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count; case inequality so unknowns never match
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Read a word and compare it
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rchk
  // Pulse must be high two cycles after the sample and gone a cycle later
  task automatic pulse();
    @(posedge clk);
    #1;
    chk("pulse high", {15'h0000, cl_int}, 16'h0001);
    @(posedge clk);
    #1;
    chk("pulse low", {15'h0000, cl_int}, 16'h0000);
  endtask : pulse
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Hang guard, well beyond the hundred or fewer cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) rchk(ra[i], rv[i]);
    rchk(OFF_FLAGS, 16'h0004);
    chk("pin", {15'h0000, pin}, 16'h0001);
    chk("irq", {15'h0000, irq}, 16'h0001);
    u_host.wr(OFF_OPCFG_B, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("pin off", {15'h0000, pin}, 16'h0000);
    u_host.wr(OFF_OPCFG_B, 16'h0001);
    // Charge up past the low capacity threshold, so the flag clears
    u_host.smp(16'h0e74, 16'h0100, 1'b1);
    repeat (2) @(posedge clk);
    rchk(OFF_REM_CAP, 16'h0100);
    rchk(OFF_NOM_CAP, 16'h0100);
    rchk(OFF_FAV_CAP, 16'h03e8);
    rchk(OFF_FULL_CAP, 16'h03e8);
    rchk(OFF_FLAGS, 16'h0000);
    chk("pin follows", {15'h0000, pin}, 16'h0000);
    u_host.wr(OFF_INT_STATUS, 16'h0003);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", {15'h0000, irq}, 16'h0000);
    // Drop below the shutdown set voltage
    u_host.smp(16'h0c00, 16'h0000, 1'b0);
    pulse();
    chk("irq set", {15'h0000, irq}, 16'h0001);
    rchk(OFF_FLAGS, 16'h0002);
    rchk(OFF_INT_STATUS, 16'h0001);
    // Loaded drop below the open circuit level at 25 percent charge
    rchk(OFF_IMPEDANCE, 16'h00e4);
    // Rise above the clear voltage while discharging a small quantum
    u_host.smp(16'h0d00, 16'h0010, 1'b0);
    pulse();
    rchk(OFF_FLAGS, 16'h0000);
    rchk(OFF_REM_CAP, 16'h00f0);
    // Masking the pending shutdown event drops the level interrupt
    u_host.wr(OFF_INT_MASK, 16'h0002);
    @(posedge clk);
    #1;
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    // Discharged to the final voltage: state of charge reads zero
    u_host.smp(16'h0b00, 16'h0000, 1'b0);
    repeat (2) @(posedge clk);
    rchk(OFF_SOC, 16'h0000);
    rchk(OFF_FLAGS, 16'h0006);
    chk("irq unmasked", {15'h0000, irq}, 16'h0001);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
